// ==== mac_defines.vh ====
`ifndef MAC_DEFINES_VH
`define MAC_DEFINES_VH

// Operation codes presented on op_code.
`define MAC_OP_W          4
`define MAC_OP_NONE       4'h0
`define MAC_OP_MULT       4'h1
`define MAC_OP_MULTU      4'h2
`define MAC_OP_DIV        4'h3
`define MAC_OP_DIVU       4'h4
`define MAC_OP_MFUPPER    4'h5
`define MAC_OP_MFLOWER    4'h6
`define MAC_OP_DIRECT_MUL 4'h7
`define MAC_OP_MULTIPLY_ADD_ACC       4'h8
`define MAC_OP_MADDU      4'h9
`define MAC_OP_MULTIPLY_SUBTRACT_ACC       4'ha
`define MAC_OP_MSUBU      4'hb

// Reset values of the accumulator pair.
`define MAC_UPPER_RST     32'h00000000
`define MAC_LOWER_RST     32'h00000000

// Cycles that busy stays high for one divide, the cycle the result lands included.
`define MAC_DIV_BUSY_CYCLES 6'h21

`endif

// ==== mac_divider.v ====
`timescale 1ns/100ps
`default_nettype none

// Restoring divider, one quotient bit per cycle.
module mac_divider #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         start,
  input  wire         signed_op,
  input  wire [W-1:0] dividend,
  input  wire [W-1:0] divisor,
  output reg          busy_r,
  output reg          done_r,
  output reg  [W-1:0] quot_r,
  output reg  [W-1:0] rem_r
);

  reg  [W-1:0] q_r;
  reg  [W-1:0] d_r;
  reg  [W:0]   p_r;
  reg  [5:0]   cnt_r;
  reg          negq_r;
  reg          negr_r;
  wire [W-1:0] a_abs  = (signed_op && dividend[W-1]) ? (~dividend + 1'b1) : dividend;
  wire [W-1:0] b_abs  = (signed_op && divisor[W-1]) ? (~divisor + 1'b1) : divisor;
  wire [W:0]   shl    = {p_r[W-1:0], q_r[W-1]};
  wire [W:0]   diff   = shl - {1'b0, d_r};
  wire [W-1:0] p_fin  = diff[W] ? shl[W-1:0] : diff[W-1:0];
  wire [W-1:0] q_fin  = {q_r[W-2:0], ~diff[W]};

  always @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      quot_r <= {W{1'b0}};
      rem_r  <= {W{1'b0}};
      q_r    <= {W{1'b0}};
      d_r    <= {W{1'b0}};
      p_r    <= {(W+1){1'b0}};
      cnt_r  <= 6'h00;
      negq_r <= 1'b0;
      negr_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        q_r    <= a_abs;
        d_r    <= b_abs;
        p_r    <= {(W+1){1'b0}};
        cnt_r  <= W[5:0];
        negq_r <= signed_op && (dividend[W-1] ^ divisor[W-1]);
        negr_r <= signed_op && dividend[W-1];
      end else if (busy_r) begin
        q_r   <= q_fin;
        p_r   <= {1'b0, p_fin};
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          quot_r <= negq_r ? (~q_fin + 1'b1) : q_fin;
          rem_r  <= negr_r ? (~p_fin + 1'b1) : p_fin;
        end
      end
    end
  end

endmodule // mac_divider

`default_nettype wire

// ==== mac_regfile_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mac_regfile_model (
  input wire logic        clk,
  input wire logic        we,
  input wire logic [4:0]  waddr,
  input wire logic [31:0] wdata
);
  logic [31:0] mem [0:31];
  // Writes land only on the strobe edge, so a stray data change cannot leak in.
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // mac_regfile_model
`default_nettype wire

// ==== mac_unit.v ====
`timescale 1ns/100ps
`default_nettype none
`include "mac_defines.vh"

module mac_unit #(
  parameter W  = 32,
  parameter RW = 5
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          op_valid,
  input  wire [3:0]    op_code,
  input  wire [W-1:0]  op_a,
  input  wire [W-1:0]  op_b,
  input  wire [RW-1:0] op_dest,
  output reg           busy_r,
  output reg           gpr_we_r,
  output reg  [RW-1:0] gpr_waddr_r,
  output reg  [W-1:0]  gpr_wdata_r,
  output reg  [W-1:0]  upper_accumulator_r,
  output reg  [W-1:0]  lower_accumulator_r
);

  // Divide sequencer states.
  localparam [0:0] ST_IDLE    = 1'b0;
  localparam [0:0] ST_DIV     = 1'b1;

  // Sources of the next accumulator pair.
  localparam [2:0] SRC_HOLD   = 3'h0;
  localparam [2:0] SRC_PROD   = 3'h1;
  localparam [2:0] SRC_ADD    = 3'h2;
  localparam [2:0] SRC_SUB    = 3'h3;
  localparam [2:0] SRC_DIV    = 3'h4;

  // Sources of the register-file write data.
  localparam [1:0] WSRC_HOLD  = 2'h0;
  localparam [1:0] WSRC_UPPER = 2'h1;
  localparam [1:0] WSRC_LOWER = 2'h2;
  localparam [1:0] WSRC_PROD  = 2'h3;

  wire            take      = op_valid && !busy_r;
  wire            is_mult_s = (op_code == `MAC_OP_MULT);
  wire            is_multiply_add_acc_s = (op_code == `MAC_OP_MULTIPLY_ADD_ACC);
  wire            is_multiply_subtract_acc_s = (op_code == `MAC_OP_MULTIPLY_SUBTRACT_ACC);
  wire            is_dmul   = (op_code == `MAC_OP_DIRECT_MUL);
  wire            is_div_s  = (op_code == `MAC_OP_DIV);
  wire            is_div_u  = (op_code == `MAC_OP_DIVU);
  wire            sgn_mul   = is_mult_s || is_multiply_add_acc_s || is_multiply_subtract_acc_s || is_dmul;
  wire            div_start = take && (is_div_s || is_div_u);

  // Sign-extended operands let one unsigned multiplier serve both flavours.
  wire [2*W-1:0]  a_ext     = sgn_mul ? {{W{op_a[W-1]}}, op_a} : {{W{1'b0}}, op_a};
  wire [2*W-1:0]  b_ext     = sgn_mul ? {{W{op_b[W-1]}}, op_b} : {{W{1'b0}}, op_b};
  wire [4*W-1:0]  prod_full = a_ext * b_ext;
  wire [2*W-1:0]  prod      = prod_full[2*W-1:0];
  wire [2*W-1:0]  pair      = {upper_accumulator_r, lower_accumulator_r};
  wire [2*W-1:0]  pair_add  = pair + prod;
  wire [2*W-1:0]  pair_sub  = pair - prod;

  wire            div_done;
  wire [W-1:0]    div_q;
  wire [W-1:0]    div_r;

  mac_divider #(
    .W (W)
  ) u_div (
    .clk       (clk),
    .rst       (rst),
    .start     (div_start),
    .signed_op (is_div_s),
    .dividend  (op_a),
    .divisor   (op_b),
    .busy_r    (),
    .done_r    (div_done),
    .quot_r    (div_q),
    .rem_r     (div_r)
  );

  reg [0:0]   state_r;
  reg [0:0]   state_nxt;
  reg [2:0]   pair_src;
  reg [1:0]   wr_src;
  reg         we_nxt;
  reg [W-1:0] upper_nxt;
  reg [W-1:0] lower_nxt;
  reg [W-1:0] wd_nxt;

  // Busy stays up until the divider result has landed in the pair, so that no
  // request can be taken, and lost, in the cycle the pair is written.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (div_start) begin
          state_nxt = ST_DIV;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @* begin
    pair_src = SRC_HOLD;
    wr_src   = WSRC_HOLD;
    we_nxt   = 1'b0;
    if (div_done) begin
      pair_src = SRC_DIV;
    end else if (take) begin
      case (op_code)
        `MAC_OP_MULT, `MAC_OP_MULTU: begin
          pair_src = SRC_PROD;
        end
        `MAC_OP_MULTIPLY_ADD_ACC, `MAC_OP_MADDU: begin
          pair_src = SRC_ADD;
        end
        `MAC_OP_MULTIPLY_SUBTRACT_ACC, `MAC_OP_MSUBU: begin
          pair_src = SRC_SUB;
        end
        `MAC_OP_MFUPPER: begin
          we_nxt = 1'b1;
          wr_src = WSRC_UPPER;
        end
        `MAC_OP_MFLOWER: begin
          we_nxt = 1'b1;
          wr_src = WSRC_LOWER;
        end
        `MAC_OP_DIRECT_MUL: begin
          // The pair is left untouched so a running accumulation survives.
          we_nxt = 1'b1;
          wr_src = WSRC_PROD;
        end
        default: begin
          pair_src = SRC_HOLD;
          we_nxt   = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    upper_nxt = upper_accumulator_r;
    lower_nxt = lower_accumulator_r;
    case (pair_src)
      SRC_PROD: begin
        upper_nxt = prod[2*W-1:W];
        lower_nxt = prod[W-1:0];
      end
      SRC_ADD: begin
        upper_nxt = pair_add[2*W-1:W];
        lower_nxt = pair_add[W-1:0];
      end
      SRC_SUB: begin
        upper_nxt = pair_sub[2*W-1:W];
        lower_nxt = pair_sub[W-1:0];
      end
      SRC_DIV: begin
        // Remainder to upper and quotient to lower, as the pair convention expects.
        upper_nxt = div_r;
        lower_nxt = div_q;
      end
      default: begin
        upper_nxt = upper_accumulator_r;
        lower_nxt = lower_accumulator_r;
      end
    endcase
  end

  always @* begin
    wd_nxt = gpr_wdata_r;
    case (wr_src)
      WSRC_UPPER: begin
        wd_nxt = upper_accumulator_r;
      end
      WSRC_LOWER: begin
        wd_nxt = lower_accumulator_r;
      end
      WSRC_PROD: begin
        wd_nxt = prod[W-1:0];
      end
      default: begin
        wd_nxt = gpr_wdata_r;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt == ST_DIV);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      gpr_we_r    <= 1'b0;
      gpr_waddr_r <= {RW{1'b0}};
      gpr_wdata_r <= {W{1'b0}};
    end else begin
      gpr_we_r    <= we_nxt;
      if (take) begin
        gpr_waddr_r <= op_dest;
      end
      gpr_wdata_r <= wd_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      upper_accumulator_r <= `MAC_UPPER_RST;
      lower_accumulator_r <= `MAC_LOWER_RST;
    end else begin
      upper_accumulator_r <= upper_nxt;
      lower_accumulator_r <= lower_nxt;
    end
  end

endmodule // mac_unit

`default_nettype wire

// ==== mac_unit_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module mac_unit_properties #(
  parameter W  = 32,
  parameter RW = 5
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          op_valid,
  input wire logic [3:0]    op_code,
  input wire logic [W-1:0]  op_a,
  input wire logic [W-1:0]  op_b,
  input wire logic [RW-1:0] op_dest,
  input wire logic          busy_r,
  input wire logic          gpr_we_r,
  input wire logic [RW-1:0] gpr_waddr_r,
  input wire logic [W-1:0]  gpr_wdata_r,
  input wire logic [W-1:0]  upper_accumulator_r,
  input wire logic [W-1:0]  lower_accumulator_r
);
  wire logic         take = op_valid && !busy_r;
  wire logic [2*W-1:0] pair = {upper_accumulator_r, lower_accumulator_r};
  wire logic [2*W-1:0] ps   = $signed(op_a) * $signed(op_b);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_ORD_NO_GPR: assert property (take && op_code >= 4'h1 && op_code <= 4'h4 |=> !gpr_we_r)
    else $error("ordinary multiply or divide wrote the register file");
  AST_MOVE: assert property (take && (op_code == 4'h5 || op_code == 4'h6) |=> gpr_we_r &&
    gpr_wdata_r == $past(op_code == 4'h5 ? upper_accumulator_r : lower_accumulator_r))
    else $error("move did not copy the accumulator");
  AST_DMUL_DATA: assert property (take && op_code == 4'h7 |=> gpr_we_r && gpr_wdata_r == $past(ps[W-1:0]))
    else $error("direct multiply wrote wrong low word");
  AST_DMUL_DEST: assert property (take && op_code == 4'h7 |=> gpr_waddr_r == $past(op_dest))
    else $error("direct multiply wrote wrong register");
  AST_MULTIPLY_ADD_ACC: assert property (take && op_code == 4'h8 |=> pair == $past(pair + ps))
    else $error("multiply-add sum wrong");
  AST_MULTIPLY_SUBTRACT_ACC: assert property (take && op_code == 4'ha |=> pair == $past(pair - ps))
    else $error("multiply-subtract difference wrong");
  AST_MULT: assert property (take && op_code == 4'h1 |=> pair == $past(ps))
    else $error("product split across the pair wrong");
  AST_DIV_HOLD: assert property (take && op_code == 4'h3 |=> busy_r[*8])
    else $error("divide did not hold busy");
  cover property (take && op_code == 4'h8);
  cover property (take && op_code == 4'h3);
  cover property (take && op_code == 4'h5);
endmodule // mac_unit_properties
bind mac_unit mac_unit_properties #(.W(W), .RW(RW)) u_mac_unit_properties (.clk(clk), .rst(rst),
  .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_dest(op_dest),
  .busy_r(busy_r), .gpr_we_r(gpr_we_r), .gpr_waddr_r(gpr_waddr_r), .gpr_wdata_r(gpr_wdata_r),
  .upper_accumulator_r(upper_accumulator_r), .lower_accumulator_r(lower_accumulator_r));
`default_nettype wire

// ==== mac_unit_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mac_defines.vh"
module mac_unit_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0;
  logic [3:0]  op_code = 4'h0;
  logic [31:0] op_a = 32'h0;
  logic [31:0] op_b = 32'h0;
  logic [4:0]  op_dest = 5'h0;
  wire logic        busy_r;
  wire logic        we;
  wire logic [4:0]  wa;
  wire logic [31:0] wd;
  wire logic [31:0] up;
  wire logic [31:0] lo;
  int err_count = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  mac_unit u_mac_unit (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_a(op_a),
    .op_b(op_b), .op_dest(op_dest), .busy_r(busy_r), .gpr_we_r(we), .gpr_waddr_r(wa),
    .gpr_wdata_r(wd), .upper_accumulator_r(up), .lower_accumulator_r(lo));
  mac_regfile_model u_mac_regfile_model (.clk(clk), .we(we), .waddr(wa), .wdata(wd));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task issue(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b, input logic [4:0] d);
    @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    op_a = a;
    op_b = b;
    op_dest = d;
  endtask
  task idle(input int n);
    @(negedge clk);
    op_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task t_mult;
    issue(4'h1, 32'hfffffffd, 32'h7, 5'h3);
    issue(4'h5, 32'h0, 32'h0, 5'h3);
    issue(4'h6, 32'h0, 32'h0, 5'h4);
    idle(2);
    chk({up, lo}, 64'hffffffffffffffeb);
    chk(u_mac_regfile_model.mem[3], 64'hffffffff);
    chk(u_mac_regfile_model.mem[4], 64'hffffffeb);
    $display("multiply and move test finished");
  endtask
  task t_acc;
    issue(4'h8, 32'h5, 32'h4, 5'h0);
    issue(4'ha, 32'hffffffff, 32'h2, 5'h0);
    issue(4'hb, 32'hffffffff, 32'h2, 5'h0);
    issue(4'h9, 32'hffffffff, 32'hffffffff, 5'h0);
    idle(2);
    chk({up, lo}, 64'hfffffffc00000004);
    $display("accumulate test finished");
  endtask
  task t_dmul;
    issue(4'h7, 32'hfffffffa, 32'h7, 5'h1f);
    idle(0);
    chk({we, wa, wd}, {1'b1, 5'h1f, 32'hffffffd6});
    @(negedge clk);
    chk(we, 1'b0);
    chk(u_mac_regfile_model.mem[31], 64'hffffffd6);
    chk({up, lo}, 64'hfffffffc00000004);
    $display("direct multiply test finished");
  endtask
  task t_codes;
    issue(4'h2, 32'hffffffff, 32'hffffffff, 5'h2);
    issue(4'hf, 32'h3, 32'h3, 5'h5);
    chk(we, 1'b0);
    issue(4'h0, 32'h3, 32'h3, 5'h6);
    chk(we, 1'b0);
    idle(0);
    chk(we, 1'b0);
    chk({up, lo}, 64'hfffffffe00000001);
    $display("unsigned multiply and unknown code test finished");
  endtask
  task div_wait(input logic [63:0] exp);
    int n;
    n = 1;
    while (n < 40 && busy_r === 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      err_count++;
      $display("BAD %0t divide never finished", $time);
      close_out();
    end
    chk(n, `MAC_DIV_BUSY_CYCLES);
    chk({up, lo}, exp);
  endtask
  task t_div;
    issue(4'h3, 32'hffffff9c, 32'h7, 5'h0);
    issue(4'h1, 32'h9, 32'h9, 5'h0);
    idle(0);
    div_wait(64'hfffffffefffffff2);
    issue(4'h4, 32'hffffff9c, 32'h7, 5'h0);
    issue(4'h8, 32'h9, 32'h9, 5'h0);
    idle(0);
    div_wait(64'h0000000224924916);
    $display("divide test finished");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_mult();
    t_acc();
    t_dmul();
    t_codes();
    t_div();
    close_out();
  end
endmodule // mac_unit_test
`default_nettype wire
